// ### design/sfbfe_pkg.sv
package sfbfe_pkg;
   // Instruction codes decoded at the link
   localparam logic [7:0] OP_DUAL_OUT    = 8'h3B;
   localparam logic [7:0] OP_DUAL_IO     = 8'hBB;
   localparam logic [7:0] OP_QUAD_OUT    = 8'h6B;
   localparam logic [7:0] OP_QUAD_IO     = 8'hEB;
   localparam logic [7:0] OP_WORD_QIO    = 8'hE7;
   localparam logic [7:0] OP_OCTAL_QIO   = 8'hE3;
   localparam logic [7:0] OP_ENTER_QUAD  = 8'h38;
   localparam logic [7:0] OP_EXIT_QUAD   = 8'hFF;
   localparam logic [7:0] OP_SW_RESET    = 8'h99;

   // Lane width codes
   localparam logic [1:0] LW_1           = 2'h0;
   localparam logic [1:0] LW_2           = 2'h1;
   localparam logic [1:0] LW_4           = 2'h2;
   localparam logic [3:0] BYTE_BITS      = 4'h8;

   // Hard restart timing
   localparam int         RESTART_NS     = 1000;
   localparam int         CORE_MHZ       = 100;
   localparam int         RESTART_CYC    = (RESTART_NS * CORE_MHZ + 999) / 1000;

   // Synchroniser bit positions
   localparam int         SY_SEL         = 0;
   localparam int         SY_WP          = 1;
   localparam int         SY_L3          = 2;
   localparam int         SY_RST         = 3;
   localparam int         SY_RXT         = 4;
   localparam int         SY_ACK         = 5;
   localparam int         SY_QPI         = 6;
   localparam int         SY_PAUSE       = 7;
   localparam int         SY_W           = 8;

   typedef enum logic [2:0] {
      PH_OPCODE = 3'b000,
      PH_ADDR   = 3'b001,
      PH_DUMMY  = 3'b010,
      PH_OUT    = 3'b011,
      PH_IN     = 3'b100
   } sfbfe_phase_type;
endpackage

// ### design/sfbfe_front_end.sv
// Operation
// - Deselected device floats all data lanes
// - No instruction before first select falling edge
// - Single lane samples serial_in on rising
// - Single lane drives serial_out on falling
// - Wide lanes: host rising, device falling
// - Four-lane reads need quad_unlock_bit set
// - write_guard_n with guard bits blocks writes (code: guard bit 0 only, and only while quad_unlock_bit is clear)
// - Pause floats output, ignores input and clock
// - Eight-pin lane3 is pause or restart
// - Sixteen-pin restart pin always works
// - Only SPI modes 0 and 3
// - 3Bh and BBh use two lanes
// - Four-lane reads use all four lanes
// - 38h enters, FFh leaves four-lane command mode
// - Quad mode opcode in two clocks
// - Reset and 99h return to SPI mode
// - Four-lane command mode needs quad_unlock_bit
// - Pause only in single and two lane
// - Pause starts now if clock low
// - Pause ends now if clock low
// - Pause keeps partial instruction state
// - Restart-select bit picks pause or restart
// - Restart low one microsecond resets device
`timescale 1ns/1ns
module sfbfe_front_end #(
   parameter int EIGHT_PIN  = 1,
   parameter int ADDR_BYTES = 3,
   parameter int DUMMY_CLKS = 8
) (
   // Core clock and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_rst,
   // Link pins
   input  wire logic       i_sck,
   input  wire logic       i_select_n,
   input  wire logic [3:0] i_io_lane,
   output logic      [3:0] o_io_lane,
   output logic      [3:0] o_io_lane_oe,
   input  wire logic       i_hard_restart_n,
   // Configuration bits
   input  wire logic       i_quad_unlock_bit,
   input  wire logic       i_pause_or_restart_bit,
   input  wire logic [1:0] i_status_write_guard_bits,
   // Received bytes
   output logic            o_rx_valid,
   output logic      [7:0] o_rx_byte,
   output logic            o_rx_is_opcode,
   // Read data
   input  wire logic       i_tx_valid,
   input  wire logic [7:0] i_tx_byte,
   output logic            o_tx_ready,
   // Status
   output logic            o_four_lane_command_mode,
   output logic            o_selected,
   output logic            o_pause_active,
   output logic            o_status_write_blocked,
   output logic            o_restart
);
   if (ADDR_BYTES < 1 || ADDR_BYTES > 15 || DUMMY_CLKS < 0 || DUMMY_CLKS > 15) begin : g_bad_cfg
      $error("sfbfe_front_end: address bytes or dummy clocks out of range");
   end

   localparam logic [3:0] ADDR_LAST  = 4'(ADDR_BYTES - 1);
   localparam logic [3:0] DUMMY_LAST = 4'(DUMMY_CLKS - 1);
   localparam logic [7:0] RST_LAST   = 8'(sfbfe_pkg::RESTART_CYC - 1);

   // Core domain state
   logic [sfbfe_pkg::SY_W-1:0] a_in;
   logic [sfbfe_pkg::SY_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
   logic [7:0]                 rcnt_reg, rcnt_next;
   logic                       rst_link_reg, rst_link_next;
   logic                       restart_reg, restart_next;
   logic                       rxv_reg, rxv_next;
   logic [7:0]                 rxb_reg, rxb_next;
   logic                       rxo_reg, rxo_next;
   logic [7:0]                 tx_hold_reg, tx_hold_next;
   logic                       tx_full_reg, tx_full_next;
   logic                       blocked_reg, blocked_next;
   logic                       rst_pin_n;
   logic [sfbfe_pkg::SY_W-1:0] chg;

   // Link domain state
   logic                       frame_rst;
   logic                       pause_req, pause_en, pause_act;
   logic                       qpi_reg, qpi_next;
   logic                       rx_tog_reg, rx_tog_next;
   logic [7:0]                 rx_byte_reg, rx_byte_next;
   logic                       rx_first_reg, rx_first_next;
   logic                       qe1_reg, qe2_reg, por1_reg, por2_reg;
   sfbfe_pkg::sfbfe_phase_type phase_reg, phase_next;
   logic [3:0]                 bit_cnt_reg, bit_cnt_next;
   logic [7:0]                 sh_reg, sh_next;
   logic [3:0]                 cnt_reg, cnt_next;
   logic [1:0]                 in_lw_reg, in_lw_next;
   logic [1:0]                 in_lw_eff;
   logic                       prise_reg, prise_next;
   logic [1:0]                 out_lw_reg, out_lw_next;
   logic [3:0]                 step;
   logic                       shifting, byte_done;
   logic [7:0]                 out_sh_reg, out_sh_next;
   logic [3:0]                 out_cnt_reg, out_cnt_next;
   logic [3:0]                 out_reg, out_next;
   logic                       out_vld_reg, out_vld_next;
   logic                       pfall_reg, pfall_next;
   logic                       load_evt;
   logic                       ack_tog_reg, ack_tog_next;
   logic [3:0]                 ostep;
   logic [7:0]                 obyte;
   logic [3:0]                 lane_mask;

   // Core: three-flop input filtering
   assign a_in = {pause_act, qpi_reg, ack_tog_reg, rx_tog_reg,
                  i_hard_restart_n, i_io_lane[3], i_io_lane[2], i_select_n};
   assign chg  = filt_next ^ filt_reg;

   always_comb begin
      filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
      if (EIGHT_PIN != 0) begin
         rst_pin_n = i_quad_unlock_bit | ~i_pause_or_restart_bit | filt_reg[sfbfe_pkg::SY_L3];
      end else begin
         rst_pin_n = filt_reg[sfbfe_pkg::SY_RST];
      end
      rcnt_next    = rcnt_reg;
      restart_next = 1'b0;
      if (!rst_pin_n) begin
         if (rcnt_reg != RST_LAST) begin
            rcnt_next = rcnt_reg + 8'h01;
         end
         restart_next = (rcnt_reg == RST_LAST - 8'h01);
      end else begin
         rcnt_next = 8'h00;
      end
      rst_link_next = rst_link_reg;
      if (!rst_pin_n || restart_reg) begin
         rst_link_next = 1'b1;
      end else if (filt_reg[sfbfe_pkg::SY_SEL]) begin
         rst_link_next = 1'b0;
      end
      rxv_next = chg[sfbfe_pkg::SY_RXT];
      rxb_next = rxb_reg;
      rxo_next = rxo_reg;
      if (chg[sfbfe_pkg::SY_RXT]) begin
         rxb_next = rx_byte_reg;
         rxo_next = rx_first_reg;
      end
      tx_hold_next = tx_hold_reg;
      tx_full_next = tx_full_reg;
      if (i_tx_valid && !tx_full_reg) begin
         tx_hold_next = i_tx_byte;
         tx_full_next = 1'b1;
      end else if (chg[sfbfe_pkg::SY_ACK]) begin
         tx_full_next = 1'b0;
      end
      blocked_next = ~i_quad_unlock_bit & i_status_write_guard_bits[0] & ~filt_reg[sfbfe_pkg::SY_WP];
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         s1_reg       <= 8'h0F;
         s2_reg       <= 8'h0F;
         s3_reg       <= 8'h0F;
         filt_reg     <= 8'h0F;
         rcnt_reg     <= 8'h00;
         rst_link_reg <= 1'b1;
         restart_reg  <= 1'b0;
         rxv_reg      <= 1'b0;
         rxb_reg      <= 8'h00;
         rxo_reg      <= 1'b0;
         tx_hold_reg  <= 8'h00;
         tx_full_reg  <= 1'b0;
         blocked_reg  <= 1'b0;
      end else begin
         s1_reg       <= a_in;
         s2_reg       <= s1_reg;
         s3_reg       <= s2_reg;
         filt_reg     <= filt_next;
         rcnt_reg     <= rcnt_next;
         rst_link_reg <= rst_link_next;
         restart_reg  <= restart_next;
         rxv_reg      <= rxv_next;
         rxb_reg      <= rxb_next;
         rxo_reg      <= rxo_next;
         tx_hold_reg  <= tx_hold_next;
         tx_full_reg  <= tx_full_next;
         blocked_reg  <= blocked_next;
      end
   end

   assign o_rx_valid               = rxv_reg;
   assign o_rx_byte                = rxb_reg;
   assign o_rx_is_opcode           = rxo_reg;
   assign o_tx_ready               = ~tx_full_reg;
   assign o_four_lane_command_mode = filt_reg[sfbfe_pkg::SY_QPI];
   assign o_selected               = ~filt_reg[sfbfe_pkg::SY_SEL];
   assign o_pause_active           = filt_reg[sfbfe_pkg::SY_PAUSE];
   assign o_status_write_blocked   = blocked_reg;
   assign o_restart                = restart_reg;

   // Link: frame reset and pause
   assign frame_rst = i_select_n | rst_link_reg;
   assign pause_en  = ~qe2_reg & ~((EIGHT_PIN != 0) & por2_reg) & ~qpi_reg
                      & (in_lw_reg != sfbfe_pkg::LW_4) & (out_lw_reg != sfbfe_pkg::LW_4);
   assign pause_req = ~i_io_lane[3] & pause_en;
   assign pause_act = ~i_select_n & (i_sck ? prise_reg : pause_req);
   assign in_lw_eff = (qpi_reg && phase_reg == sfbfe_pkg::PH_OPCODE) ? sfbfe_pkg::LW_4 : in_lw_reg;

   // Link: rising edge input path
   always_comb begin
      case (in_lw_eff)
         sfbfe_pkg::LW_2: begin
            step    = 4'h2;
            sh_next = {sh_reg[5:0], i_io_lane[1:0]};
         end
         sfbfe_pkg::LW_4: begin
            step    = 4'h4;
            sh_next = {sh_reg[3:0], i_io_lane};
         end
         default: begin
            step    = 4'h1;
            sh_next = {sh_reg[6:0], i_io_lane[0]};
         end
      endcase
      shifting     = !pause_req && (phase_reg != sfbfe_pkg::PH_OUT) && (phase_reg != sfbfe_pkg::PH_DUMMY);
      byte_done    = shifting && (bit_cnt_reg + step == sfbfe_pkg::BYTE_BITS);
      phase_next   = phase_reg;
      bit_cnt_next = bit_cnt_reg;
      cnt_next     = cnt_reg;
      in_lw_next   = in_lw_reg;
      out_lw_next  = out_lw_reg;
      prise_next   = pause_req;
      if (shifting) begin
         bit_cnt_next = byte_done ? 4'h0 : bit_cnt_reg + step;
      end
      if (byte_done && phase_reg == sfbfe_pkg::PH_OPCODE) begin
         phase_next = sfbfe_pkg::PH_ADDR;
         cnt_next   = 4'h0;
         case (sh_next)
            sfbfe_pkg::OP_DUAL_OUT: begin
               out_lw_next = sfbfe_pkg::LW_2;
            end
            sfbfe_pkg::OP_DUAL_IO: begin
               in_lw_next  = sfbfe_pkg::LW_2;
               out_lw_next = sfbfe_pkg::LW_2;
            end
            sfbfe_pkg::OP_QUAD_OUT: begin
               out_lw_next = sfbfe_pkg::LW_4;
            end
            sfbfe_pkg::OP_QUAD_IO, sfbfe_pkg::OP_WORD_QIO, sfbfe_pkg::OP_OCTAL_QIO: begin
               in_lw_next  = sfbfe_pkg::LW_4;
               out_lw_next = sfbfe_pkg::LW_4;
            end
            default: begin
               phase_next = sfbfe_pkg::PH_IN;
            end
         endcase
         if (out_lw_next == sfbfe_pkg::LW_4 && !qe2_reg) begin
            phase_next  = sfbfe_pkg::PH_IN;
            in_lw_next  = sfbfe_pkg::LW_1;
            out_lw_next = sfbfe_pkg::LW_1;
         end
         if (qpi_reg) begin
            in_lw_next = sfbfe_pkg::LW_4;
            if (phase_next == sfbfe_pkg::PH_ADDR) begin
               out_lw_next = sfbfe_pkg::LW_4;
            end
         end
      end else if (byte_done && phase_reg == sfbfe_pkg::PH_ADDR) begin
         cnt_next = cnt_reg + 4'h1;
         if (cnt_reg == ADDR_LAST) begin
            cnt_next   = 4'h0;
            phase_next = (DUMMY_CLKS == 0) ? sfbfe_pkg::PH_OUT : sfbfe_pkg::PH_DUMMY;
         end
      end else if (phase_reg == sfbfe_pkg::PH_DUMMY && !pause_req) begin
         cnt_next = cnt_reg + 4'h1;
         if (cnt_reg == DUMMY_LAST) begin
            phase_next = sfbfe_pkg::PH_OUT;
         end
      end
   end

   always_ff @(posedge i_sck or posedge frame_rst) begin
      if (frame_rst) begin
         phase_reg   <= sfbfe_pkg::PH_OPCODE;
         bit_cnt_reg <= 4'h0;
         sh_reg      <= 8'h00;
         cnt_reg     <= 4'h0;
         in_lw_reg   <= sfbfe_pkg::LW_1;
         out_lw_reg  <= sfbfe_pkg::LW_1;
         prise_reg   <= 1'b0;
      end else begin
         phase_reg   <= phase_next;
         bit_cnt_reg <= bit_cnt_next;
         sh_reg      <= shifting ? sh_next : sh_reg;
         cnt_reg     <= cnt_next;
         in_lw_reg   <= in_lw_next;
         out_lw_reg  <= out_lw_next;
         prise_reg   <= prise_next;
      end
   end

   // Link: mode and received-byte hand-off
   always_comb begin
      qpi_next      = qpi_reg;
      rx_tog_next   = rx_tog_reg;
      rx_byte_next  = rx_byte_reg;
      rx_first_next = rx_first_reg;
      if (!frame_rst && byte_done) begin
         rx_tog_next   = ~rx_tog_reg;
         rx_byte_next  = sh_next;
         rx_first_next = (phase_reg == sfbfe_pkg::PH_OPCODE);
         if (phase_reg == sfbfe_pkg::PH_OPCODE) begin
            if (sh_next == sfbfe_pkg::OP_ENTER_QUAD && qe2_reg) begin
               qpi_next = 1'b1;
            end else if (sh_next == sfbfe_pkg::OP_EXIT_QUAD || sh_next == sfbfe_pkg::OP_SW_RESET) begin
               qpi_next = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge i_sck or posedge rst_link_reg) begin
      if (rst_link_reg) begin
         qpi_reg      <= 1'b0;
         rx_tog_reg   <= 1'b0;
         rx_byte_reg  <= 8'h00;
         rx_first_reg <= 1'b0;
         qe1_reg      <= 1'b0;
         qe2_reg      <= 1'b0;
         por1_reg     <= 1'b0;
         por2_reg     <= 1'b0;
      end else begin
         qpi_reg      <= qpi_next;
         rx_tog_reg   <= rx_tog_next;
         rx_byte_reg  <= rx_byte_next;
         rx_first_reg <= rx_first_next;
         qe1_reg      <= i_quad_unlock_bit;
         qe2_reg      <= qe1_reg;
         por1_reg     <= i_pause_or_restart_bit;
         por2_reg     <= por1_reg;
      end
   end

   // Link: falling edge output path
   always_comb begin
      case (out_lw_reg)
         sfbfe_pkg::LW_2: begin
            ostep     = 4'h2;
            lane_mask = 4'h3;
         end
         sfbfe_pkg::LW_4: begin
            ostep     = 4'h4;
            lane_mask = 4'hF;
         end
         default: begin
            ostep     = 4'h1;
            lane_mask = 4'h2;
         end
      endcase
      pfall_next   = pause_req;
      load_evt     = 1'b0;
      out_sh_next  = out_sh_reg;
      out_cnt_next = out_cnt_reg;
      out_next     = out_reg;
      out_vld_next = out_vld_reg;
      obyte        = out_sh_reg;
      if (phase_reg == sfbfe_pkg::PH_OUT && !pfall_reg) begin
         if (out_cnt_reg == 4'h0) begin
            obyte    = tx_hold_reg;
            load_evt = 1'b1;
         end
         out_sh_next  = obyte << ostep;
         out_cnt_next = out_cnt_reg == 4'h0 ? sfbfe_pkg::BYTE_BITS - ostep : out_cnt_reg - ostep;
         out_vld_next = 1'b1;
         case (out_lw_reg)
            sfbfe_pkg::LW_2: out_next = {2'b00, obyte[7:6]};
            sfbfe_pkg::LW_4: out_next = obyte[7:4];
            default:         out_next = {2'b00, obyte[7], 1'b0};
         endcase
      end
   end

   always_ff @(negedge i_sck or posedge frame_rst) begin
      if (frame_rst) begin
         out_sh_reg  <= 8'h00;
         out_cnt_reg <= 4'h0;
         out_reg     <= 4'h0;
         out_vld_reg <= 1'b0;
         pfall_reg   <= 1'b0;
      end else begin
         out_sh_reg  <= out_sh_next;
         out_cnt_reg <= out_cnt_next;
         out_reg     <= out_next;
         out_vld_reg <= out_vld_next;
         pfall_reg   <= pfall_next;
      end
   end

   always_comb begin
      ack_tog_next = ack_tog_reg ^ (load_evt & ~frame_rst);
   end

   always_ff @(negedge i_sck or posedge rst_link_reg) begin
      if (rst_link_reg) begin
         ack_tog_reg <= 1'b0;
      end else begin
         ack_tog_reg <= ack_tog_next;
      end
   end

   // Pin drive
   assign o_io_lane    = out_reg;
   assign o_io_lane_oe = (~i_select_n & out_vld_reg & ~pause_act) ? lane_mask : 4'h0;

   desel_hiz_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      i_select_n |-> o_io_lane_oe == 4'h0) else $error("lanes driven while deselected");
   pause_float_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      pause_act |-> o_io_lane_oe == 4'h0) else $error("lanes driven during pause");
   quad_gate_a: assert property (@(posedge i_sck) disable iff (rst_link_reg)
      $rose(qpi_reg) |-> $past(qe2_reg)) else $error("quad command mode without unlock");
   sw_reset_a: assert property (@(posedge i_sck) disable iff (rst_link_reg)
      (byte_done && phase_reg == sfbfe_pkg::PH_OPCODE && sh_next == sfbfe_pkg::OP_SW_RESET) |=> !qpi_reg)
      else $error("software reset left quad command mode");
   opcode_width_a: assert property (@(posedge i_sck) disable iff (frame_rst)
      (byte_done && phase_reg == sfbfe_pkg::PH_OPCODE) |-> bit_cnt_reg == (qpi_reg ? 4'h4 : 4'h7))
      else $error("opcode length wrong");
   wide_lanes_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (o_io_lane_oe[2] || o_io_lane_oe[3]) |-> (out_lw_reg == sfbfe_pkg::LW_4 && o_io_lane_oe == 4'hF))
      else $error("upper lanes driven outside four-lane read");
   restart_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      !rst_pin_n |=> rst_link_reg ##1 (rst_link_reg || $past(rst_pin_n)))
      else $error("commands accepted while restart low");
   guard_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (!i_quad_unlock_bit && i_status_write_guard_bits[0] && !filt_reg[sfbfe_pkg::SY_WP]) |=> o_status_write_blocked)
      else $error("status write not blocked");
endmodule

// ### dv/sfbfe_host_model.sv
`timescale 1ns/1ns
module sfbfe_host_model (
   // Core clock for the floating-line pattern
   input  wire logic       i_core_clk,
   // Device lane drive
   input  wire logic [3:0] i_dev_lane,
   input  wire logic [3:0] i_dev_oe,
   // Link pins
   output logic            o_sck,
   output logic            o_select_n,
   output logic      [3:0] o_lane
);
   logic [3:0] host_out;
   logic [3:0] host_oe;
   logic       wp_n;
   logic       hold_n;
   logic       flip;
   logic       mode3;

   initial begin
      o_sck = 1'h0;
      o_select_n = 1'h1;
      host_out = 4'h0;
      host_oe = 4'h0;
      wp_n = 1'h1;
      hold_n = 1'h1;
      flip = 1'h0;
      mode3 = 1'h0;
   end

   // Released lanes: wp_n and hold_n levels on lanes 2 and 3, a toggling pattern elsewhere
   always @(posedge i_core_clk) flip <= ~flip;
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         if (i_dev_oe[k] === 1'h1)
            o_lane[k] = i_dev_lane[k];
         else if (host_oe[k])
            o_lane[k] = host_out[k];
         else
            o_lane[k] = (k == 2) ? wp_n : (k == 3) ? hold_n : flip ^ k[0];
      end
   end

   // Idle clock level picks the mode, then select falls
   task automatic fr_open(input logic m3);
      mode3 = m3;
      o_sck = m3;
      #20;
      o_select_n = 1'h0;
      #20;
   endtask

   // Host changes lanes after a fall and samples at the rise
   task automatic clocks(input int w, input int n, input logic rd, input logic [31:0] d,
                         output logic [31:0] q);
      q = 32'h0;
      for (int c = 0; c < n; c++) begin
         o_sck = 1'h0;
         host_oe = rd ? 4'h0 : 4'((1 << w) - 1);
         host_out = 4'(d >> (32 - w));
         d = d << w;
         #16;
         o_sck = 1'h1;
         q = (q << w) | 32'(o_lane & 4'((1 << w) - 1));
         #16;
      end
   endtask

   task automatic lo();
      o_sck = 1'h0;
      #16;
   endtask

   // Select stays low until here, pauses included
   task automatic fr_close();
      if (!mode3)
         o_sck = 1'h0;
      host_oe = 4'h0;
      #16;
      o_select_n = 1'h1;
      #40;
   endtask

   task automatic pins(input logic wp, input logic hold);
      wp_n = wp;
      hold_n = hold;
   endtask
endmodule

// ### dv/tb_serial_flash_bus_front_end.sv
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
   $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb_serial_flash_bus_front_end;
   logic        i_core_clk = 1'h0;
   logic        i_rst = 1'h1;
   logic        i_quad_unlock_bit = 1'h0;
   logic        i_pause_or_restart_bit = 1'h0;
   logic [1:0]  i_status_write_guard_bits = 2'h0;
   logic        i_tx_valid = 1'h0;
   logic [7:0]  i_tx_byte = 8'h0;
   logic        sck, sel_n, o_rx_valid, o_rx_is_opcode, o_tx_ready, o_four_lane_command_mode;
   logic        o_selected, o_pause_active, o_status_write_blocked, o_restart;
   logic [3:0]  lane, o_io_lane, o_io_lane_oe;
   logic [7:0]  o_rx_byte, op, b;
   logic [31:0] q;
   logic [8:0]  rxq[$];
   int          fail_count = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   int          restarts = 0;
   int          aw, dw;

   always #5 i_core_clk = ~i_core_clk;

   sfbfe_front_end sfbfe_front_end_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_sck(sck),
      .i_select_n(sel_n), .i_io_lane(lane), .o_io_lane(o_io_lane), .o_io_lane_oe(o_io_lane_oe),
      .i_hard_restart_n(1'h1), .i_quad_unlock_bit(i_quad_unlock_bit),
      .i_pause_or_restart_bit(i_pause_or_restart_bit), .i_status_write_guard_bits(i_status_write_guard_bits),
      .o_rx_valid(o_rx_valid), .o_rx_byte(o_rx_byte), .o_rx_is_opcode(o_rx_is_opcode),
      .i_tx_valid(i_tx_valid), .i_tx_byte(i_tx_byte), .o_tx_ready(o_tx_ready),
      .o_four_lane_command_mode(o_four_lane_command_mode), .o_selected(o_selected),
      .o_pause_active(o_pause_active), .o_status_write_blocked(o_status_write_blocked),
      .o_restart(o_restart));

   sfbfe_host_model sfbfe_host_model_i (.i_core_clk(i_core_clk), .i_dev_lane(o_io_lane),
      .i_dev_oe(o_io_lane_oe), .o_sck(sck), .o_select_n(sel_n), .o_lane(lane));

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge i_core_clk) begin
      cycles++;
      if (o_rx_valid === 1'h1)
         rxq.push_back({o_rx_is_opcode, o_rx_byte});
      if (o_restart === 1'h1)
         restarts++;
      if (cycles == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask

   task automatic expect_rx(input logic [8:0] e);
      logic [8:0] g;
      g = 9'hX;
      for (int n = 0; n < 20 && rxq.size() == 0; n++)
         @(posedge i_core_clk);
      if (rxq.size() > 0)
         g = rxq.pop_front();
      `CHK("rx byte", e, g)
   endtask

   task automatic put_tx(input logic [7:0] v);
      @(posedge i_core_clk);
      for (int n = 0; n < 100 && o_tx_ready !== 1'h1; n++)
         @(posedge i_core_clk);
      i_tx_valid <= 1'h1;
      i_tx_byte <= v;
      @(posedge i_core_clk);
      i_tx_valid <= 1'h0;
   endtask

   task automatic op_frame(input int w, input logic [7:0] v);
      sfbfe_host_model_i.fr_open(1'h0);
      sfbfe_host_model_i.clocks(w, 8 / w, 1'h0, {v, 24'h0}, q);
      sfbfe_host_model_i.fr_close();
      cyc(20);
   endtask

   initial begin
      void'($urandom(77));
      cyc(10);
      i_rst <= 1'h0;
      cyc(10);
      `CHK("oe idle", 4'h0, o_io_lane_oe)
      `CHK("mode reset", 1'h0, o_four_lane_command_mode)
      for (int t = 0; t < 6; t++) begin
         rxq.delete();
         op = {3'h2, 5'($urandom)};
         b = 8'($urandom);
         sfbfe_host_model_i.fr_open(t[0]);
         sfbfe_host_model_i.clocks(1, 16, 1'h0, {op, b, 16'h0}, q);
         sfbfe_host_model_i.fr_close();
         expect_rx({1'h1, op});
         expect_rx({1'h0, b});
         `CHK("oe deselected", 4'h0, o_io_lane_oe)
      end
      for (int t = 0; t < 4; t++) begin
         aw = (t == 1) ? 2 : (t == 3) ? 4 : 1;
         dw = (t < 2) ? 2 : 4;
         op = (t == 0) ? sfbfe_pkg::OP_DUAL_OUT : (t == 1) ? sfbfe_pkg::OP_DUAL_IO :
              (t == 2) ? sfbfe_pkg::OP_QUAD_OUT : sfbfe_pkg::OP_QUAD_IO;
         b = 8'($urandom);
         i_quad_unlock_bit <= (dw == 4);
         put_tx(b);
         cyc(10);
         sfbfe_host_model_i.fr_open(1'h0);
         sfbfe_host_model_i.clocks(1, 8, 1'h0, {op, 24'h0}, q);
         sfbfe_host_model_i.clocks(aw, 24 / aw, 1'h0, $urandom, q);
         sfbfe_host_model_i.clocks(1, 8, 1'h1, 32'h0, q);
         sfbfe_host_model_i.clocks(dw, 8 / dw, 1'h1, 32'h0, q);
         `CHK("read byte", b, q[7:0])
         sfbfe_host_model_i.fr_close();
         cyc(20);
      end
      i_quad_unlock_bit <= 1'h0;
      cyc(10);
      op_frame(1, sfbfe_pkg::OP_ENTER_QUAD);
      `CHK("locked entry", 1'h0, o_four_lane_command_mode)
      i_quad_unlock_bit <= 1'h1;
      cyc(10);
      op_frame(1, sfbfe_pkg::OP_ENTER_QUAD);
      `CHK("quad enter", 1'h1, o_four_lane_command_mode)
      op_frame(4, sfbfe_pkg::OP_EXIT_QUAD);
      `CHK("quad exit", 1'h0, o_four_lane_command_mode)
      op_frame(1, sfbfe_pkg::OP_ENTER_QUAD);
      op_frame(4, sfbfe_pkg::OP_SW_RESET);
      `CHK("sw reset", 1'h0, o_four_lane_command_mode)
      sfbfe_host_model_i.fr_open(1'h0);
      sfbfe_host_model_i.pins(1'h1, 1'h0);
      cyc(10);
      `CHK("no quad pause", 1'h0, o_pause_active)
      sfbfe_host_model_i.pins(1'h1, 1'h1);
      sfbfe_host_model_i.fr_close();
      i_quad_unlock_bit <= 1'h0;
      cyc(10);
      rxq.delete();
      op = {3'h2, 5'($urandom)};
      sfbfe_host_model_i.fr_open(1'h0);
      sfbfe_host_model_i.clocks(1, 4, 1'h0, {op, 24'h0}, q);
      sfbfe_host_model_i.lo();
      sfbfe_host_model_i.pins(1'h1, 1'h0);
      cyc(10);
      `CHK("pause on", 1'h1, o_pause_active)
      `CHK("pause float", 4'h0, o_io_lane_oe)
      `CHK("selected", 1'h1, o_selected)
      sfbfe_host_model_i.clocks(1, 3, 1'h0, $urandom, q);
      sfbfe_host_model_i.lo();
      sfbfe_host_model_i.pins(1'h1, 1'h1);
      cyc(10);
      `CHK("pause off", 1'h0, o_pause_active)
      sfbfe_host_model_i.clocks(1, 4, 1'h0, {op[3:0], 28'h0}, q);
      sfbfe_host_model_i.fr_close();
      expect_rx({1'h1, op});
      i_status_write_guard_bits <= 2'h1;
      sfbfe_host_model_i.pins(1'h0, 1'h1);
      cyc(10);
      `CHK("guard on", 1'h1, o_status_write_blocked)
      i_quad_unlock_bit <= 1'h1;
      cyc(10);
      `CHK("guard as lane", 1'h0, o_status_write_blocked)
      i_quad_unlock_bit <= 1'h0;
      sfbfe_host_model_i.pins(1'h1, 1'h1);
      cyc(10);
      `CHK("guard off", 1'h0, o_status_write_blocked)
      i_pause_or_restart_bit <= 1'h1;
      cyc(5);
      restarts = 0;
      sfbfe_host_model_i.pins(1'h1, 1'h0);
      cyc(60);
      `CHK("restart early", 0, restarts)
      cyc(90);
      `CHK("restart", 1, restarts)
      sfbfe_host_model_i.pins(1'h1, 1'h1);
      cyc(10);
      tally_and_finish();
   end
endmodule
